// File: rtl/obcd_top.sv
// option byte store, programming-mode register access and configuration decode
//
// What this block does
// R1 - option bytes have no normal address; reachable only in programming mode
// R2 - blank option byte storage holds all ones
// R3 - factory coded parts use fixed option values, writes are ignored
// R4 - byte 0 bit 1 picks 44 or 64 pins; bits 7:2 kept at one
// R5 - byte 0 bit 0 set blocks external reads of program memory
// R6 - clearing protection rewrites whole program memory, option bytes untouched
// R7 - protection bit does not guard data eeprom in programmable parts
// R8 - byte 1 bit 7 low enables clock supervision, high disables it
// R9 - byte 1 bits 6:4 select the main oscillator source
// R10 - byte 1 bits 3:2 select voltage detector threshold or off
// R11 - byte 1 bit 1 set makes halt with active watchdog reset
// R12 - byte 1 bit 0 low hardware watchdog, high software enabled
// R13 - decoded settings sampled at reset and held until next reset
`timescale 1ns/1ps
`default_nettype none
module obcd_top
    import obcd_pkg::*;
#(
    parameter bit FACTORY_CODED = 1'b0,
    parameter logic [7:0] FACTORY_OB0 = OBCD_OB0_FACTORY_DEFAULT,
    parameter logic [7:0] FACTORY_OB1 = OBCD_OB1_FACTORY_DEFAULT,
    parameter bit FACTORY_EEPROM_PROTECT = 1'b0,
    parameter int PM_WORDS = OBCD_PM_WORDS,
    parameter int PM_ADDR_W = $clog2(PM_WORDS)
) (
    input wire logic clk_i,                          // core clock, 40 MHz
    input wire logic rst_i,                          // synchronous reset, active high
    input wire logic reload_i,                       // device reset pulse, re-samples options
    input wire logic prog_mode_i,                    // programming mode pin, asynchronous
    input wire logic wb_cyc_i,                       // wishbone cycle
    input wire logic wb_stb_i,                       // wishbone strobe
    input wire logic wb_we_i,                        // wishbone write enable
    input wire logic [OBCD_ADR_W-1:0] wb_adr_i,      // wishbone byte address
    input wire logic [3:0] wb_sel_i,                 // wishbone byte selects
    input wire logic [31:0] wb_dat_i,                // wishbone write data
    output logic [31:0] wb_dat_o,                    // wishbone read data
    output logic wb_ack_o,                           // wishbone acknowledge
    output logic package_64pin_o,                    // 1: 64-pin bonding, 0: 44-pin
    output logic readout_protect_bit_o,              // latched readout protection
    output logic clock_supervisor_disable_o,         // 1: clock supervision off
    output logic [2:0] oscillator_select_o,          // decoded oscillator kind
    output logic lvd_enable_o,                       // voltage detector on
    output logic [1:0] low_voltage_threshold_select_o, // raw threshold code
    output logic watchdog_halt_reset_o,              // reset on halt with watchdog active
    output logic watchdog_software_mode_o,           // 1: software started watchdog
    output logic watchdog_always_on_o,               // hardware watchdog running
    output logic pm_ext_read_block_o,                // block external program memory reads
    output logic eeprom_ext_read_block_o,            // block external eeprom reads
    output logic pm_erase_busy_o,                    // erase sweep running
    output logic pm_erase_we_o,                      // rewrite strobe to program memory
    output logic [PM_ADDR_W-1:0] pm_erase_addr_o     // program memory word rewritten
);

    // programming mode pin synchroniser
    logic prog_meta_q, prog_sync_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prog_meta_q <= 1'b0;
            prog_sync_q <= 1'b0;
        end else begin
            prog_meta_q <= prog_mode_i;
            prog_sync_q <= prog_meta_q;
        end
    end

    // bus decode
    logic req;
    logic wr_req;
    logic sel_ob0, sel_ob1, sel_status, sel_latched;
    logic erase_busy;
    logic erase_start;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_req = req && wb_we_i && wb_sel_i[0];
    assign sel_ob0 = (wb_adr_i == OBCD_ADR_OB0) && prog_sync_q;          // see R1
    assign sel_ob1 = (wb_adr_i == OBCD_ADR_OB1) && prog_sync_q;          // see R1
    assign sel_latched = (wb_adr_i == OBCD_ADR_LATCHED) && prog_sync_q;  // see R1
    assign sel_status = (wb_adr_i == OBCD_ADR_STATUS);

    // nonvolatile option byte storage
    logic [7:0] ob0_q, ob0_d;
    logic [7:0] ob1_q, ob1_d;
    logic [7:0] ob0_eff, ob1_eff;

    // factory parts ignore the store and answer with the hard-wired bytes
    assign ob0_eff = FACTORY_CODED ? (FACTORY_OB0 | OBCD_OB0_RSVD_MASK) : ob0_q;  // see R3, R4
    assign ob1_eff = FACTORY_CODED ? FACTORY_OB1 : ob1_q;                        // see R3

    always_comb begin
        ob0_d = ob0_q;
        ob1_d = ob1_q;
        erase_start = 1'b0;
        if (wr_req && !FACTORY_CODED && !erase_busy) begin  // see R3
            if (sel_ob0) begin
                ob0_d = wb_dat_i[7:0] | OBCD_OB0_RSVD_MASK;  // see R4
                // removing protection triggers the sweep; option bytes are not part of it
                if (ob0_q[OBCD_OB0_PROT_BIT] && !wb_dat_i[OBCD_OB0_PROT_BIT]) begin
                    erase_start = 1'b1;  // see R6
                end
            end
            if (sel_ob1) begin
                ob1_d = wb_dat_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ob0_q <= OBCD_BLANK;  // see R2
            ob1_q <= OBCD_BLANK;  // see R2
        end else begin
            ob0_q <= ob0_d;
            ob1_q <= ob1_d;
        end
    end

    // erase sweep
    logic [PM_ADDR_W-1:0] erase_addr;
    logic erase_we;

    obcd_erase_seq #(
        .PM_WORDS(PM_WORDS),
        .ADDR_W(PM_ADDR_W)
    ) u_erase (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(erase_start),  // see R6
        .busy_o(erase_busy),
        .we_o(erase_we),
        .addr_o(erase_addr)
    );

    // configuration latch: loaded in the cycle after reset release or a reload pulse
    logic load_q, load_d;
    logic [7:0] lat0_q, lat0_d;
    logic [7:0] lat1_q, lat1_d;
    logic pkg_q, pkg_d;
    logic prot_q, prot_d;
    logic cksup_q, cksup_d;
    logic [2:0] osc_q, osc_d;
    logic lvd_en_q, lvd_en_d;
    logic [1:0] lvd_q, lvd_d;
    logic wdh_q, wdh_d;
    logic wds_q, wds_d;
    logic wdon_q, wdon_d;
    logic [2:0] osc_raw;

    assign osc_raw = ob1_eff[OBCD_OB1_OSC_HI:OBCD_OB1_OSC_LO];

    always_comb begin
        load_d = reload_i;
        lat0_d = lat0_q;
        lat1_d = lat1_q;
        pkg_d = pkg_q;
        prot_d = prot_q;
        cksup_d = cksup_q;
        osc_d = osc_q;
        lvd_en_d = lvd_en_q;
        lvd_d = lvd_q;
        wdh_d = wdh_q;
        wds_d = wds_q;
        wdon_d = wdon_q;
        // outside a load the outputs stay frozen, later writes wait for the next reset
        if (load_q) begin  // see R13
            lat0_d = ob0_eff;
            lat1_d = ob1_eff;
            pkg_d = ob0_eff[OBCD_OB0_PKG_BIT];                              // see R4
            prot_d = ob0_eff[OBCD_OB0_PROT_BIT];                            // see R5
            cksup_d = ob1_eff[OBCD_OB1_CKSUP_BIT];                          // see R8
            case (osc_raw)                                                   // see R9
                3'h7: osc_d = OBCD_OSC_EXT_CLK;
                3'h6: osc_d = OBCD_OSC_INT_RC;
                3'h5, 3'h4: osc_d = OBCD_OSC_EXT_RC;
                3'h3: osc_d = OBCD_OSC_LOW_POWER;
                3'h2: osc_d = OBCD_OSC_MED_POWER;
                3'h1: osc_d = OBCD_OSC_MED_SPEED;
                default: osc_d = OBCD_OSC_HIGH_SPEED;
            endcase
            lvd_d = ob1_eff[OBCD_OB1_LVD_HI:OBCD_OB1_LVD_LO];               // see R10
            lvd_en_d = (ob1_eff[OBCD_OB1_LVD_HI:OBCD_OB1_LVD_LO] != OBCD_LVD_OFF);  // see R10
            wdh_d = ob1_eff[OBCD_OB1_WDH_BIT];                              // see R11
            wds_d = ob1_eff[OBCD_OB1_WDS_BIT];                              // see R12
            wdon_d = !ob1_eff[OBCD_OB1_WDS_BIT];                            // see R12
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            load_q <= 1'b1;  // see R13
            lat0_q <= OBCD_BLANK;
            lat1_q <= OBCD_BLANK;
            pkg_q <= 1'b1;
            prot_q <= 1'b1;
            cksup_q <= 1'b1;
            osc_q <= OBCD_OSC_EXT_CLK;
            lvd_en_q <= 1'b0;
            lvd_q <= OBCD_LVD_OFF;
            wdh_q <= 1'b1;
            wds_q <= 1'b1;
            wdon_q <= 1'b0;
        end else begin
            load_q <= load_d;
            lat0_q <= lat0_d;
            lat1_q <= lat1_d;
            pkg_q <= pkg_d;
            prot_q <= prot_d;
            cksup_q <= cksup_d;
            osc_q <= osc_d;
            lvd_en_q <= lvd_en_d;
            lvd_q <= lvd_d;
            wdh_q <= wdh_d;
            wds_q <= wds_d;
            wdon_q <= wdon_d;
        end
    end

    // program memory read guard follows the stored bit so a fresh set takes effect at once
    logic pm_block_q, pm_block_d;
    logic ee_block_q, ee_block_d;

    always_comb begin
        // reads stay blocked while the sweep has not finished overwriting the memory
        pm_block_d = ob0_eff[OBCD_OB0_PROT_BIT] || erase_busy || erase_start;  // see R5, R6
        // only factory parts can guard the eeprom, and by their own fixed choice
        ee_block_d = FACTORY_CODED ? FACTORY_EEPROM_PROTECT : 1'b0;           // see R7
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pm_block_q <= 1'b1;
            ee_block_q <= 1'b0;
        end else begin
            pm_block_q <= pm_block_d;
            ee_block_q <= ee_block_d;
        end
    end

    // bus answer: every request is acknowledged one cycle after it is presented
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic [31:0] status_word;

    always_comb begin
        status_word = OBCD_ZERO_WORD;
        status_word[OBCD_STS_PROG_BIT] = prog_sync_q;
        status_word[OBCD_STS_BUSY_BIT] = erase_busy;
        status_word[OBCD_STS_FACT_BIT] = FACTORY_CODED;
        status_word[OBCD_STS_PROT_BIT] = ob0_eff[OBCD_OB0_PROT_BIT];
    end

    always_comb begin
        ack_d = req;
        rdat_d = OBCD_ZERO_WORD;
        // outside programming mode the option bytes read as zero, like unmapped space
        if (req && !wb_we_i) begin
            if (sel_ob0) begin
                rdat_d = {24'h00_0000, ob0_eff};  // see R1
            end else if (sel_ob1) begin
                rdat_d = {24'h00_0000, ob1_eff};  // see R1
            end else if (sel_latched) begin
                rdat_d = {16'h0000, lat1_q, lat0_q};
            end else if (sel_status) begin
                rdat_d = status_word;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= OBCD_ZERO_WORD;
        end else begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    // erase port outputs are registered once more to keep them off the sequencer logic
    logic er_busy_q, er_we_q;
    logic [PM_ADDR_W-1:0] er_addr_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            er_busy_q <= 1'b0;
            er_we_q <= 1'b0;
            er_addr_q <= '0;
        end else begin
            er_busy_q <= erase_busy;
            er_we_q <= erase_we;
            er_addr_q <= erase_addr;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign package_64pin_o = pkg_q;
    assign readout_protect_bit_o = prot_q;
    assign clock_supervisor_disable_o = cksup_q;
    assign oscillator_select_o = osc_q;
    assign lvd_enable_o = lvd_en_q;
    assign low_voltage_threshold_select_o = lvd_q;
    assign watchdog_halt_reset_o = wdh_q;
    assign watchdog_software_mode_o = wds_q;
    assign watchdog_always_on_o = wdon_q;
    assign pm_ext_read_block_o = pm_block_q;
    assign eeprom_ext_read_block_o = ee_block_q;
    assign pm_erase_busy_o = er_busy_q;
    assign pm_erase_we_o = er_we_q;
    assign pm_erase_addr_o = er_addr_q;

endmodule
`default_nettype wire

// File: common/obcd_pkg.sv
// shared constants and types of the option byte configuration decoder
package obcd_pkg;

    // register byte addresses (one aligned 32-bit word each)
    localparam int OBCD_ADR_W = 8;
    localparam logic [7:0] OBCD_ADR_OB0 = 8'h00;
    localparam logic [7:0] OBCD_ADR_OB1 = 8'h04;
    localparam logic [7:0] OBCD_ADR_STATUS = 8'h08;
    localparam logic [7:0] OBCD_ADR_LATCHED = 8'h0C;

    // values after reset and fixed masks
    localparam logic [7:0] OBCD_BLANK = 8'hFF;
    localparam logic [7:0] OBCD_OB0_RSVD_MASK = 8'hFC;
    localparam logic [7:0] OBCD_OB0_FACTORY_DEFAULT = 8'hFE;
    localparam logic [7:0] OBCD_OB1_FACTORY_DEFAULT = 8'hEF;
    localparam logic [31:0] OBCD_ZERO_WORD = 32'h0000_0000;

    // option byte 0 fields
    localparam int OBCD_OB0_PKG_BIT = 1;
    localparam int OBCD_OB0_PROT_BIT = 0;

    // option byte 1 fields
    localparam int OBCD_OB1_CKSUP_BIT = 7;
    localparam int OBCD_OB1_OSC_HI = 6;
    localparam int OBCD_OB1_OSC_LO = 4;
    localparam int OBCD_OB1_LVD_HI = 3;
    localparam int OBCD_OB1_LVD_LO = 2;
    localparam int OBCD_OB1_WDH_BIT = 1;
    localparam int OBCD_OB1_WDS_BIT = 0;

    // status register fields
    localparam int OBCD_STS_PROG_BIT = 0;
    localparam int OBCD_STS_BUSY_BIT = 1;
    localparam int OBCD_STS_FACT_BIT = 2;
    localparam int OBCD_STS_PROT_BIT = 3;

    // program memory size in words swept by the erase
    localparam int OBCD_PM_WORDS = 16384;

    typedef enum logic [2:0] {
        OBCD_OSC_HIGH_SPEED = 3'h0,
        OBCD_OSC_MED_SPEED = 3'h1,
        OBCD_OSC_MED_POWER = 3'h2,
        OBCD_OSC_LOW_POWER = 3'h3,
        OBCD_OSC_EXT_RC = 3'h4,
        OBCD_OSC_INT_RC = 3'h6,
        OBCD_OSC_EXT_CLK = 3'h7
    } obcd_osc_e;

    typedef enum logic [1:0] {
        OBCD_LVD_LOW = 2'h0,
        OBCD_LVD_MID = 2'h1,
        OBCD_LVD_HIGH = 2'h2,
        OBCD_LVD_OFF = 2'h3
    } obcd_lvd_e;

    typedef enum logic [1:0] {
        OBCD_ER_IDLE = 2'h0,
        OBCD_ER_RUN = 2'h1,
        OBCD_ER_LAST = 2'h3
    } obcd_er_state_e;

endpackage

// File: rtl/obcd_erase_seq.sv
// program memory erase sweep started when readout protection is removed
`timescale 1ns/1ps
`default_nettype none
module obcd_erase_seq
    import obcd_pkg::*;
#(
    parameter int PM_WORDS = OBCD_PM_WORDS,
    parameter int ADDR_W = $clog2(PM_WORDS)
) (
    input wire logic clk_i,                 // core clock
    input wire logic rst_i,                 // synchronous reset, active high
    input wire logic start_i,               // one-cycle start pulse
    output logic busy_o,                    // sweep in progress
    output logic we_o,                      // rewrite strobe for addr_o
    output logic [ADDR_W-1:0] addr_o        // word being rewritten
);

    localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(PM_WORDS - 1);

    obcd_er_state_e state_q, state_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic we_q, we_d;

    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        we_d = 1'b0;
        case (state_q)
            OBCD_ER_IDLE: begin
                if (start_i) begin
                    state_d = OBCD_ER_RUN;
                    addr_d = '0;
                    we_d = 1'b1;
                end
            end
            OBCD_ER_RUN: begin
                // each word is rewritten with the value its cells already latch
                if (addr_q == LAST_ADDR) begin
                    state_d = OBCD_ER_LAST;
                end else begin
                    addr_d = addr_q + 1'b1;
                    we_d = 1'b1;
                end
            end
            OBCD_ER_LAST: begin
                state_d = OBCD_ER_IDLE;
            end
            default: begin
                state_d = OBCD_ER_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= OBCD_ER_IDLE;
            addr_q <= '0;
            we_q <= 1'b0;
        end else begin
            state_q <= state_d;
            addr_q <= addr_d;
            we_q <= we_d;
        end
    end

    assign busy_o = (state_q != OBCD_ER_IDLE);
    assign we_o = we_q;
    assign addr_o = addr_q;

endmodule
`default_nettype wire

// File: verification/obcd_properties.sv
// concurrent checks on the ports of the option byte decoder
`timescale 1ns/1ps
`default_nettype none
module obcd_properties
    import obcd_pkg::*;
#(
    parameter bit FACTORY_CODED = 1'b0,
    parameter int PM_WORDS = 16,
    parameter int PM_ADDR_W = 4
) (
    input wire logic clk_i, // core clock
    input wire logic rst_i, // sync reset
    input wire logic reload_i, // device reset pulse
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // bus strobe
    input wire logic [31:0] wb_dat_o, // read data
    input wire logic wb_ack_o, // acknowledge
    input wire logic package_64pin_o, // package pick
    input wire logic readout_protect_bit_o, // latched protection
    input wire logic clock_supervisor_disable_o, // supervision off
    input wire logic [2:0] oscillator_select_o, // oscillator kind
    input wire logic lvd_enable_o, // detector on
    input wire logic [1:0] low_voltage_threshold_select_o, // threshold code
    input wire logic watchdog_halt_reset_o, // reset on halt
    input wire logic watchdog_software_mode_o, // software watchdog
    input wire logic watchdog_always_on_o, // hardware watchdog
    input wire logic pm_ext_read_block_o, // program memory block
    input wire logic eeprom_ext_read_block_o, // eeprom block
    input wire logic pm_erase_busy_o, // sweep running
    input wire logic pm_erase_we_o, // rewrite strobe
    input wire logic [PM_ADDR_W-1:0] pm_erase_addr_o // rewritten word
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // settings may move up to three edges after a reset or reload, so look back four
    logic [3:0] recent_q;
    logic [3:0] recent_d;
    always_comb recent_d = {recent_q[2:0], rst_i | reload_i};
    always_ff @(posedge clk_i) recent_q <= recent_d;

    sequence s_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_last_word;
        pm_erase_we_o && pm_erase_addr_o == PM_ADDR_W'(PM_WORDS - 1);
    endsequence

    AST_ACK_PULSE: assert property (s_taken |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus request not answered by a single ack");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == OBCD_ZERO_WORD)
        else $error("read data outside ack");
    AST_HOLD: assert property (!reload_i && recent_q == 4'h0 |-> $stable({package_64pin_o,
        readout_protect_bit_o, clock_supervisor_disable_o, oscillator_select_o, watchdog_halt_reset_o,
        low_voltage_threshold_select_o, watchdog_software_mode_o}))
        else $error("decoded setting changed without reset");
    AST_ERASE_STEP: assert property (pm_erase_we_o && pm_erase_addr_o != PM_ADDR_W'(PM_WORDS - 1)
        |=> pm_erase_we_o && pm_erase_addr_o == $past(pm_erase_addr_o) + 1'b1)
        else $error("erase sweep skipped a word");
    AST_ERASE_END: assert property (s_last_word |-> ##[1:3] !pm_erase_busy_o)
        else $error("erase busy stayed after last word");
    AST_WE_BUSY: assert property (pm_erase_we_o |-> pm_erase_busy_o)
        else $error("rewrite strobe outside sweep");
    AST_BLOCK: assert property (pm_erase_busy_o |-> pm_ext_read_block_o)
        else $error("program memory open during erase");
    AST_EE_OPEN: assert property (1'b1 |-> FACTORY_CODED || !eeprom_ext_read_block_o)
        else $error("eeprom blocked in programmable part");
    AST_LVD: assert property (lvd_enable_o == (low_voltage_threshold_select_o != 2'h3))
        else $error("detector enable does not match code");
    AST_WDG: assert property (watchdog_always_on_o == !watchdog_software_mode_o)
        else $error("watchdog kind outputs disagree");
endmodule
bind obcd_top obcd_properties #(.FACTORY_CODED(FACTORY_CODED), .PM_WORDS(PM_WORDS), .PM_ADDR_W(PM_ADDR_W)) u_props (.*);
`default_nettype wire

// File: verification/obcd_pm_model.sv
// program memory stand-in that receives the erase rewrite strobes
`timescale 1ns/1ps
`default_nettype none
module obcd_pm_model #(
    parameter int PM_WORDS = 16
) (
    input wire logic clk_i, // core clock
    input wire logic rst_i, // sync reset
    input wire logic we_i, // rewrite strobe
    input wire logic [$clog2(PM_WORDS)-1:0] addr_i, // word rewritten
    output int rewrites_o, // strobes seen since reset
    output logic order_ok_o // each strobe hit the expected word
);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rewrites_o <= 0;
            order_ok_o <= 1'b1;
        end else if (we_i) begin
            rewrites_o <= rewrites_o + 1;
            // a word never swept would stay readable once protection is gone
            if (int'(addr_i) != rewrites_o % PM_WORDS) order_ok_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: verification/obcd_test.sv
// self-checking bench for the option byte decoder
`timescale 1ns/1ps
`default_nettype none
module obcd_test;
    import obcd_pkg::*;
    localparam int PMW = 16;
    logic clk_i;
    logic rst_i = 1'b1;
    logic reload_i = 1'b0;
    logic prog_mode_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, package_64pin_o, readout_protect_bit_o, clock_supervisor_disable_o, lvd_enable_o;
    logic watchdog_halt_reset_o, watchdog_software_mode_o, watchdog_always_on_o, pm_ext_read_block_o;
    logic eeprom_ext_read_block_o, pm_erase_busy_o, pm_erase_we_o, order_ok;
    logic [2:0] oscillator_select_o;
    logic [1:0] low_voltage_threshold_select_o;
    logic [3:0] pm_erase_addr_o;
    logic [31:0] rd;
    logic [7:0] s0, s1, l0, l1, b;
    int n_mismatch = 0;
    int checked = 0;
    int rewrites, base;
    wire logic [11:0] cfg = {package_64pin_o, readout_protect_bit_o, clock_supervisor_disable_o,
        oscillator_select_o, lvd_enable_o, low_voltage_threshold_select_o, watchdog_halt_reset_o,
        watchdog_software_mode_o, watchdog_always_on_o};

    obcd_top #(.PM_WORDS(PMW)) dut (.*);
    obcd_pm_model #(.PM_WORDS(PMW)) u_pm (.clk_i(clk_i), .rst_i(rst_i), .we_i(pm_erase_we_o),
        .addr_i(pm_erase_addr_o), .rewrites_o(rewrites), .order_ok_o(order_ok));

    // factory coded twin on the same bus: its answers are not read, only its fixed settings
    wire logic [11:0] f_cfg;
    wire logic f_ee;
    obcd_top #(.FACTORY_CODED(1'b1), .FACTORY_EEPROM_PROTECT(1'b1), .PM_WORDS(PMW)) u_fact (.clk_i(clk_i),
        .rst_i(rst_i), .reload_i(reload_i), .prog_mode_i(prog_mode_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(),
        .wb_ack_o(), .package_64pin_o(f_cfg[11]), .readout_protect_bit_o(f_cfg[10]),
        .clock_supervisor_disable_o(f_cfg[9]), .oscillator_select_o(f_cfg[8:6]), .lvd_enable_o(f_cfg[5]),
        .low_voltage_threshold_select_o(f_cfg[4:3]), .watchdog_halt_reset_o(f_cfg[2]),
        .watchdog_software_mode_o(f_cfg[1]), .watchdog_always_on_o(f_cfg[0]), .pm_ext_read_block_o(),
        .eeprom_ext_read_block_o(f_ee), .pm_erase_busy_o(), .pm_erase_we_o(), .pm_erase_addr_o());

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    function automatic logic [11:0] exp_cfg(input logic [7:0] b0, input logic [7:0] b1);
        logic [2:0] osc;
        osc = (b1[6:5] == 2'b10) ? 3'h4 : b1[6:4];
        return {b0[1:0], b1[7], osc, b1[3:2] != 2'h3, b1[3:1], b1[0], ~b1[0]};
    endfunction

    task automatic cmp_bus(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_cfg(input logic [11:0] got, input logic [11:0] exp);
        cmp_bus({20'h0, got}, {20'h0, exp});
    endtask

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        if (wb_ack_o !== 1'b1) n_mismatch++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0);
        cmp_bus(rd, exp);
    endtask

    task automatic reload;
        reload_i <= 1'b1;
        @(posedge clk_i);
        reload_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        l0 = s0;
        l1 = s1;
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #100000;
        n_mismatch++;
        test_done();
    end

    initial begin
        void'($urandom(32'h3128));
        s0 = OBCD_BLANK;
        s1 = OBCD_BLANK;
        l0 = s0;
        l1 = s1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        cmp_cfg(cfg, exp_cfg(l0, l1));
        cmp_cfg(f_cfg, exp_cfg(OBCD_OB0_FACTORY_DEFAULT, OBCD_OB1_FACTORY_DEFAULT));
        cmp_bus({31'h0, f_ee}, 32'h1);
        cmp_bus({31'h0, eeprom_ext_read_block_o}, 32'h0);
        wb(1'b1, OBCD_ADR_OB1, 32'h0);
        rdc(OBCD_ADR_OB1, 32'h0);
        rdc(OBCD_ADR_STATUS, 32'h8);
        prog_mode_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rdc(OBCD_ADR_OB0, 32'hFF);
        rdc(OBCD_ADR_OB1, 32'hFF);
        rdc(8'h10, 32'h0);
        rdc(OBCD_ADR_STATUS, 32'h9);
        $display("test blank done");
        for (int i = 0; i < 8; i++) begin
            b = 8'($urandom());
            s1 = {b[7], 3'(i), 2'(i), b[1:0]};
            wb(1'b1, OBCD_ADR_OB1, {24'h0, s1});
            cmp_cfg(cfg, exp_cfg(l0, l1));
            reload();
            cmp_cfg(cfg, exp_cfg(l0, l1));
            rdc(OBCD_ADR_LATCHED, {16'h0, l1, l0});
        end
        cmp_cfg(f_cfg, exp_cfg(OBCD_OB0_FACTORY_DEFAULT, OBCD_OB1_FACTORY_DEFAULT));
        $display("test decode done");
        s0 = 8'hFD;
        wb(1'b1, OBCD_ADR_OB0, 32'h01);
        rdc(OBCD_ADR_OB0, {24'h0, s0});
        reload();
        cmp_cfg(cfg, exp_cfg(l0, l1));
        $display("test package done");
        base = rewrites;
        s0 = 8'hFC;
        wb(1'b1, OBCD_ADR_OB0, 32'h0);
        wb(1'b1, OBCD_ADR_OB1, 32'h0);
        for (int n = 0; n < 100 && pm_erase_busy_o !== 1'b0; n++) @(posedge clk_i);
        cmp_bus({31'h0, pm_erase_busy_o}, 32'h0);
        cmp_bus(32'(rewrites - base), 32'(PMW));
        cmp_bus({31'h0, order_ok}, 32'h1);
        rdc(OBCD_ADR_OB0, {24'h0, s0});
        rdc(OBCD_ADR_OB1, {24'h0, s1});
        cmp_bus({31'h0, pm_ext_read_block_o}, 32'h0);
        rdc(OBCD_ADR_STATUS, 32'h1);
        reload();
        cmp_cfg(cfg, exp_cfg(l0, l1));
        s0 = 8'hFF;
        wb(1'b1, OBCD_ADR_OB0, 32'h3);
        repeat (2) @(posedge clk_i);
        cmp_bus({31'h0, pm_ext_read_block_o}, 32'h1);
        $display("test erase done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        cmp_cfg(cfg, exp_cfg(8'hFF, 8'hFF));
        cmp_cfg(f_cfg, exp_cfg(OBCD_OB0_FACTORY_DEFAULT, OBCD_OB1_FACTORY_DEFAULT));
        rdc(OBCD_ADR_OB0, 32'hFF);
        $display("test second reset done");
        test_done();
    end
endmodule
`default_nettype wire
